/* logic/umx_pkg.sv */
// shared constants and types for the multiprocessor serial port extension
// assumes both ends run on one system clock with the same bit time
package umx_pkg;
  localparam int unsigned BIT_CYC_DEF = 16; // clocks per bit time
  localparam int unsigned TICK_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned BRK_BITS = 11; // low bit times that make a break
  localparam int unsigned PORT_INDEX_DEF = 0;
  // transmit bit index: 0 start, 1..8 data, then ninth and/or stop
  localparam logic [IDX_W-1:0] TX_STOP8 = 4'h9;
  localparam logic [IDX_W-1:0] TX_STOP9 = 4'ha;
  localparam logic [IDX_W-1:0] TX_NINTH = 4'h9;
  // receive sample index: 0..7 data, then ninth and/or stop
  localparam logic [IDX_W-1:0] RX_STOP8 = 4'h8;
  localparam logic [IDX_W-1:0] RX_STOP9 = 4'h9;
  localparam logic [IDX_W-1:0] RX_NINTH = 4'h8;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE3 = 2'h3;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic LINE_LOW = 1'h0;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } umx_rx_state_type;
endpackage : umx_pkg

/* logic/umx_link_if.sv */
// serial link between the port and a remote node: one line each way
// assumes both parties are clocked by the same system clock
`timescale 1ns/10ps
interface umx_link_if;
  logic to_dev; // remote node transmit line, device receive line
  logic to_host; // device transmit line, remote node receive line
  modport dev (input to_dev, output to_host);
  modport host (output to_dev, input to_host);
endinterface : umx_link_if

/* logic/umx_dev.sv */
// device end: 9-bit receive filtering, address match, break, tx double buffer
// assumes the link line is synchronous to i_clk and the cpu drives plain ports
`timescale 1ns/10ps
module umx_dev #(
  parameter int unsigned BIT_CYCLES = umx_pkg::BIT_CYC_DEF,
  parameter int unsigned PORT_INDEX = umx_pkg::PORT_INDEX_DEF
) (
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  umx_link_if.dev link, // serial lines
  input wire logic [1:0] i_mode, // port mode 0..3
  input wire logic i_fe_select, // framing error select
  input wire logic i_multiproc_enable, // ninth bit filtering
  input wire logic i_dbl_buf_enable, // transmit double buffer
  input wire logic i_dbl_buf_irq_select, // interrupt after last char
  input wire logic i_tx_irq_late, // interrupt at end of stop
  input wire logic i_break_reset_enable, // break resets device
  input wire logic i_port_enable, // port enabled
  input wire logic [umx_pkg::DATA_W-1:0] i_node_address, // own address
  input wire logic [umx_pkg::DATA_W-1:0] i_node_address_mask, // address mask
  input wire logic i_buf_wr, // write pulse to transmit buffer
  input wire logic [umx_pkg::DATA_W-1:0] i_buf_wdata, // byte to send
  input wire logic i_tx_ninth_bit, // ninth bit to send
  input wire logic i_receive_flag_clr, // clear pulse
  input wire logic i_frame_error_clr, // clear pulse
  input wire logic i_break_clr, // clear pulse
  output logic [umx_pkg::DATA_W-1:0] o_rx_data, // received byte
  output logic o_rx_ninth_bit, // received ninth bit
  output logic o_receive_flag, // receive flag
  output logic o_frame_error_flag, // framing error flag
  output logic o_break_flag, // break detected
  output logic o_tx_irq, // transmit interrupt pulse
  output logic o_tx_busy, // shifter active
  output logic o_tx_buf_full, // double buffer holds a byte
  output logic o_break_reset // pulse: reset into boot mode
);
  import umx_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BIT_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_HALF = TICK_W'(BIT_CYCLES / 2);
  // flag on the low sample that completes eleven whole bit times
  localparam logic [TICK_W-1:0] BRK_LAST = TICK_W'(BRK_BITS * BIT_CYCLES);

  typedef struct packed {
    logic txd;
    logic tx_busy;
    logic [IDX_W-1:0] tx_idx;
    logic [TICK_W-1:0] tx_tick;
    logic [DATA_W:0] tx_sh;
    logic tx_live9;
    logic buf_full;
    logic [DATA_W:0] buf_q;
    logic tx_irq;
    umx_rx_state_type rx_st;
    logic [TICK_W-1:0] rx_tick;
    logic [IDX_W-1:0] rx_idx;
    logic [DATA_W:0] rx_sh;
    logic [DATA_W-1:0] rx_data;
    logic rx_ninth;
    logic receive_flag;
    logic frame_error_flag;
    logic [TICK_W-1:0] brk_cnt;
    logic break_flag;
    logic break_reset;
  } umx_dev_state_type;

  umx_dev_state_type s_q;
  umx_dev_state_type s_d;

  // line level for a transmit bit index
  function automatic logic tx_bit(input logic [IDX_W-1:0] idx, input logic [DATA_W:0] sh,
                                  input logic nine, input logic live9, input logic tb8);
    logic v;
    v = LINE_IDLE;
    if (idx == '0)
      v = LINE_LOW;
    else if (idx <= IDX_W'(DATA_W))
      v = sh[idx - 4'h1];
    else if (nine && idx == TX_NINTH)
      v = live9 ? tb8 : sh[DATA_W];
    return v;
  endfunction : tx_bit

  // given address: bits where mask is set must equal the node address
  function automatic logic given_match(input logic [DATA_W-1:0] rx,
                                       input logic [DATA_W-1:0] adr,
                                       input logic [DATA_W-1:0] msk);
    return ((rx ^ (adr & msk)) & msk) == '0;
  endfunction : given_match

  // broadcast address: ones of node or mask must be ones, zeros ignored
  function automatic logic bcast_match(input logic [DATA_W-1:0] rx,
                                       input logic [DATA_W-1:0] adr,
                                       input logic [DATA_W-1:0] msk);
    return (~rx & (adr | msk)) == '0;
  endfunction : bcast_match

  // next state of the whole port
  always_comb
  begin
    logic nine;
    logic mp;
    logic [IDX_W-1:0] tx_last;
    logic [IDX_W-1:0] rx_last;
    logic stop_begin;
    logic stop_end;
    logic irq_due;
    logic ninth_v;
    logic addr_ok;
    nine = i_mode[1];
    mp = i_multiproc_enable && (i_mode != MODE0);
    tx_last = nine ? TX_STOP9 : TX_STOP8;
    rx_last = nine ? RX_STOP9 : RX_STOP8;
    stop_begin = 1'b0;
    stop_end = 1'b0;
    irq_due = 1'b0;
    ninth_v = 1'b0;
    addr_ok = 1'b0;
    s_d = s_q;
    s_d.tx_irq = 1'b0;
    s_d.break_reset = 1'b0;

    // transmit: idle shifter takes a write at once
    if (!s_q.tx_busy)
    begin
      if (i_buf_wr)
      begin
        s_d.tx_busy = 1'b1;
        s_d.tx_idx = '0;
        s_d.tx_tick = '0;
        s_d.tx_sh = {i_tx_ninth_bit, i_buf_wdata};
        s_d.tx_live9 = !i_dbl_buf_enable;
        s_d.tx_irq = i_dbl_buf_enable;
      end
    end
    else
    begin
      // a write while full is dropped; software waits for the interrupt
      if (i_dbl_buf_enable && i_buf_wr && !s_q.buf_full)
      begin
        s_d.buf_full = 1'b1;
        s_d.buf_q = {i_tx_ninth_bit, i_buf_wdata};
      end
      if (s_q.tx_tick == TICK_LAST)
      begin
        s_d.tx_tick = '0;
        if (s_q.tx_idx == tx_last)
        begin
          s_d.tx_idx = '0;
          // a write in this very cycle is taken too, so the buffer never strands
          if (i_dbl_buf_enable && s_d.buf_full)
          begin
            // next start bit follows the single stop bit directly
            s_d.tx_sh = s_d.buf_q;
            s_d.tx_live9 = 1'b0;
            s_d.buf_full = 1'b0;
          end
          else
            s_d.tx_busy = 1'b0;
        end
        else
          s_d.tx_idx = s_q.tx_idx + 4'h1;
      end
      else
        s_d.tx_tick = s_q.tx_tick + 16'h1;
      // judged on the next position so the pulse lines up with the stop bit
      stop_begin = (s_d.tx_idx == tx_last) && (s_d.tx_tick == '0);
      stop_end = (s_d.tx_idx == tx_last) && (s_d.tx_tick == TICK_LAST);
      // buffered: only for a waiting byte, or the last one if selected
      irq_due = i_dbl_buf_enable ? (s_d.buf_full || i_dbl_buf_irq_select) : 1'b1;
      if (irq_due && ((stop_begin && !i_tx_irq_late)
          || (stop_end && i_tx_irq_late)))
        s_d.tx_irq = 1'b1;
    end
    s_d.txd = s_d.tx_busy
      ? tx_bit(s_d.tx_idx, s_d.tx_sh, nine, s_d.tx_live9, i_tx_ninth_bit) : LINE_IDLE;

    // software clears first so a same-cycle frame error or break wins; a frame completing as the receive flag clears is dropped
    if (i_receive_flag_clr)
      s_d.receive_flag = 1'b0;
    if (i_frame_error_clr)
      s_d.frame_error_flag = 1'b0;
    if (i_break_clr)
      s_d.break_flag = 1'b0;

    // receive: half-bit start check, then mid-bit samples
    unique case (s_q.rx_st)
      RX_IDLE:
      begin
        s_d.rx_tick = '0;
        if (link.to_dev == LINE_LOW)
          s_d.rx_st = RX_START;
      end
      RX_START:
      begin
        s_d.rx_tick = s_q.rx_tick + 16'h1;
        if (s_q.rx_tick == TICK_HALF)
        begin
          s_d.rx_tick = '0;
          s_d.rx_idx = '0;
          // a glitch shorter than half a bit is no start
          s_d.rx_st = (link.to_dev == LINE_LOW) ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA:
      begin
        s_d.rx_tick = s_q.rx_tick + 16'h1;
        if (s_q.rx_tick == TICK_LAST)
        begin
          s_d.rx_tick = '0;
          s_d.rx_idx = s_q.rx_idx + 4'h1;
          if (s_q.rx_idx != rx_last)
            s_d.rx_sh[s_q.rx_idx[3:0]] = link.to_dev;
          else
          begin
            // stop bit sampled mid-bit: flags settle during the stop bit
            s_d.rx_st = RX_IDLE;
            ninth_v = nine ? s_q.rx_sh[RX_NINTH] : link.to_dev;
            addr_ok = !(mp && nine)
              || given_match(s_q.rx_sh[DATA_W-1:0], i_node_address, i_node_address_mask)
              || bcast_match(s_q.rx_sh[DATA_W-1:0], i_node_address, i_node_address_mask);
            if (!s_q.receive_flag && (!mp || ninth_v) && addr_ok)
            begin
              s_d.rx_data = s_q.rx_sh[DATA_W-1:0];
              s_d.rx_ninth = ninth_v;
              s_d.receive_flag = 1'b1;
            end // else dropped, data and flag untouched
            if (link.to_dev == LINE_LOW
                && !(mp && i_mode == MODE3 && i_fe_select && !ninth_v))
              s_d.frame_error_flag = 1'b1;
          end
        end
      end
      default:
        s_d.rx_st = RX_IDLE;
    endcase

    // break: count low clocks, fire once per low stretch
    if (link.to_dev != LINE_LOW)
      s_d.brk_cnt = '0;
    else if (s_q.brk_cnt != BRK_LAST)
    begin
      s_d.brk_cnt = s_q.brk_cnt + 16'h1;
      if (s_d.brk_cnt == BRK_LAST)
      begin
        s_d.break_flag = 1'b1;
        s_d.break_reset = (PORT_INDEX == 0) && i_port_enable && i_break_reset_enable;
      end
    end
  end

  // state register; address and mask come from cpu registers cleared at reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.txd <= LINE_IDLE;
      s_q.rx_st <= RX_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign link.to_host = s_q.txd;
  assign o_rx_data = s_q.rx_data;
  assign o_rx_ninth_bit = s_q.rx_ninth;
  assign o_receive_flag = s_q.receive_flag;
  assign o_frame_error_flag = s_q.frame_error_flag;
  assign o_break_flag = s_q.break_flag;
  assign o_tx_irq = s_q.tx_irq;
  assign o_tx_busy = s_q.tx_busy;
  assign o_tx_buf_full = s_q.buf_full;
  assign o_break_reset = s_q.break_reset;
endmodule : umx_dev

/* logic/umx_host.sv */
// remote node end: sends 8 or 9 bit frames or a break, receives frames
// assumes the same system clock and bit time as the device end
`timescale 1ns/10ps
module umx_host #(
  parameter int unsigned BIT_CYCLES = umx_pkg::BIT_CYC_DEF
) (
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  umx_link_if.host link, // serial lines
  input wire logic i_nine, // 9-bit frames
  input wire logic i_send, // send pulse, taken when ready
  input wire logic [umx_pkg::DATA_W-1:0] i_send_data, // byte to send
  input wire logic i_send_ninth, // ninth bit, 1 marks an address
  input wire logic i_send_break, // hold line low while high
  output logic o_send_ready, // idle, can take a send
  output logic o_rx_valid, // pulse: frame received
  output logic [umx_pkg::DATA_W-1:0] o_rx_data, // received byte
  output logic o_rx_ninth, // received ninth or stop bit
  output logic o_rx_frame_error // stop bit was low
);
  import umx_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BIT_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_HALF = TICK_W'(BIT_CYCLES / 2);

  typedef struct packed {
    logic busy;
    logic [IDX_W-1:0] tx_idx;
    logic [TICK_W-1:0] tx_tick;
    logic [DATA_W+1:0] tx_frame;
    umx_rx_state_type rx_st;
    logic [TICK_W-1:0] rx_tick;
    logic [IDX_W-1:0] rx_idx;
    logic [DATA_W:0] rx_sh;
    logic rx_valid;
    logic [DATA_W-1:0] rx_data;
    logic rx_ninth;
    logic rx_fe;
  } umx_host_state_type;

  umx_host_state_type s_q;
  umx_host_state_type s_d;

  // next state of the remote node
  always_comb
  begin
    logic [IDX_W-1:0] tx_last;
    logic [IDX_W-1:0] rx_last;
    tx_last = i_nine ? TX_STOP9 : TX_STOP8;
    rx_last = i_nine ? RX_STOP9 : RX_STOP8;
    s_d = s_q;
    s_d.rx_valid = 1'b0;

    // transmit: frame is start, data lsb first, ninth only if i_nine, stop
    if (!s_q.busy)
    begin
      if (i_send && !i_send_break)
      begin
        s_d.busy = 1'b1;
        s_d.tx_idx = '0;
        s_d.tx_tick = '0;
        s_d.tx_frame = i_nine ? {LINE_IDLE, i_send_ninth, i_send_data}
                              : {LINE_IDLE, LINE_IDLE, i_send_data};
      end
    end
    else if (s_q.tx_tick == TICK_LAST)
    begin
      s_d.tx_tick = '0;
      s_d.tx_idx = s_q.tx_idx + 4'h1;
      if (s_q.tx_idx == tx_last)
        s_d.busy = 1'b0;
    end
    else
      s_d.tx_tick = s_q.tx_tick + 16'h1;

    // receive: same sampling as the device end
    unique case (s_q.rx_st)
      RX_IDLE:
      begin
        s_d.rx_tick = '0;
        if (link.to_host == LINE_LOW)
          s_d.rx_st = RX_START;
      end
      RX_START:
      begin
        s_d.rx_tick = s_q.rx_tick + 16'h1;
        if (s_q.rx_tick == TICK_HALF)
        begin
          s_d.rx_tick = '0;
          s_d.rx_idx = '0;
          s_d.rx_st = (link.to_host == LINE_LOW) ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA:
      begin
        s_d.rx_tick = s_q.rx_tick + 16'h1;
        if (s_q.rx_tick == TICK_LAST)
        begin
          s_d.rx_tick = '0;
          s_d.rx_idx = s_q.rx_idx + 4'h1;
          if (s_q.rx_idx != rx_last)
            s_d.rx_sh[s_q.rx_idx[3:0]] = link.to_host;
          else
          begin
            s_d.rx_st = RX_IDLE;
            s_d.rx_valid = 1'b1;
            s_d.rx_data = s_q.rx_sh[DATA_W-1:0];
            s_d.rx_ninth = i_nine ? s_q.rx_sh[RX_NINTH] : link.to_host;
            s_d.rx_fe = (link.to_host == LINE_LOW);
          end
        end
      end
      default:
        s_d.rx_st = RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.rx_st <= RX_IDLE;
    end
    else
      s_q <= s_d;
  end

  // line: break overrides, idle high, start low, then frame bits
  always_comb
  begin
    if (i_send_break)
      link.to_dev = LINE_LOW;
    else if (!s_q.busy)
      link.to_dev = LINE_IDLE;
    else if (s_q.tx_idx == '0)
      link.to_dev = LINE_LOW;
    else
      link.to_dev = s_q.tx_frame[s_q.tx_idx - 4'h1];
  end

  assign o_send_ready = !s_q.busy && !i_send_break;
  assign o_rx_valid = s_q.rx_valid;
  assign o_rx_data = s_q.rx_data;
  assign o_rx_ninth = s_q.rx_ninth;
  assign o_rx_frame_error = s_q.rx_fe;
endmodule : umx_host

/* bench/umx_link_monitor.sv */
// checker beside the serial link and the device end's plain ports
// assumes one clock, active-low reset, config held still during frames
`timescale 1ns/10ps
module umx_link_monitor (
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic to_dev, // host to device line
  input wire logic to_host, // device to host line
  input wire logic i_buf_wr, // buffer write pulse
  input wire logic i_dbl_buf_enable, // double buffer on
  input wire logic i_tx_irq_late, // late interrupt
  input wire logic i_multiproc_enable, // ninth bit filtering
  input wire logic i_receive_flag_clr, // clear pulse
  input wire logic i_break_clr, // clear pulse
  input wire logic i_break_reset_enable, // break resets device
  input wire logic i_port_enable, // port enabled
  input wire logic [7:0] o_rx_data, // received byte
  input wire logic o_rx_ninth_bit, // received ninth bit
  input wire logic o_receive_flag, // receive flag
  input wire logic o_break_flag, // break flag
  input wire logic o_tx_irq, // transmit interrupt
  input wire logic o_tx_busy, // shifter active
  input wire logic o_tx_buf_full, // buffer holds a byte
  input wire logic o_break_reset // boot reset pulse
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_load_irq;
    i_buf_wr && !o_tx_busy && i_dbl_buf_enable |=> !to_host && o_tx_busy && o_tx_irq;
  endproperty
  a_load_irq: assert property (p_load_irq) else $error("no load and irq on idle write");
  property p_single_noirq;
    i_buf_wr && !o_tx_busy && !i_dbl_buf_enable |=> !o_tx_irq;
  endproperty
  a_single_noirq: assert property (p_single_noirq) else $error("irq at single load");
  property p_single_refuse;
    i_buf_wr && o_tx_busy && !i_dbl_buf_enable |=> !o_tx_buf_full;
  endproperty
  a_single_refuse: assert property (p_single_refuse) else $error("single mode buffered");
  property p_full_busy;
    o_tx_buf_full |-> o_tx_busy;
  endproperty
  a_full_busy: assert property (p_full_busy) else $error("buffer full while idle");
  property p_irq_stop;
    o_tx_irq && $past(o_tx_busy) |-> to_host;
  endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("shift irq outside stop");
  property p_brk_hold;
    o_break_flag && !i_break_clr |=> o_break_flag;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break flag dropped");
  property p_brk_low;
    $rose(o_break_flag) |-> !$past(to_dev) && !$past(to_dev, 2);
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break without low line");
  property p_brk_rst;
    o_break_reset |-> o_break_flag && $past(i_break_reset_enable && i_port_enable);
  endproperty
  a_brk_rst: assert property (p_brk_rst) else $error("break reset unqualified");
  property p_mp_ninth;
    $rose(o_receive_flag) && i_multiproc_enable |-> o_rx_ninth_bit;
  endproperty
  a_mp_ninth: assert property (p_mp_ninth) else $error("flag on ninth zero");
  property p_keep_data;
    o_receive_flag && !i_receive_flag_clr |=> $stable(o_rx_data);
  endproperty
  a_keep_data: assert property (p_keep_data) else $error("data overwritten");
endmodule : umx_link_monitor

/* bench/tb.sv */
// self-checking bench: device and host ends joined by the link interface
// assumes a 4-clock bit time; config only changes between frames
`timescale 1ns/10ps
module tb;
  localparam int BC = 4; // short bit time keeps the run brief
  logic clk, nrst, fe_sel, mp, dbl, isel, late, wr, tb8, rclr, fclr, bclr;
  logic nine, send, sninth, brk, rflag, rx9, feflag, bflag, tirq, busy, full, brst;
  logic h_rdy, h_val, h_9, h_fe, bre, pen;
  logic [1:0] mode;
  logic [7:0] adr, msk, wdata, sdata, rx_data, h_data;
  logic [8:0] hd[$];
  int ht[$], ti[$];
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic seen_brst = 1'h0;
  umx_link_if link();
  umx_dev #(.BIT_CYCLES(BC), .PORT_INDEX(0)) u_umx_dev (.i_clk(clk), .i_nrst(nrst),
    .link(link.dev), .i_mode(mode), .i_fe_select(fe_sel), .i_multiproc_enable(mp),
    .i_dbl_buf_enable(dbl), .i_dbl_buf_irq_select(isel), .i_tx_irq_late(late),
    .i_break_reset_enable(bre), .i_port_enable(pen), .i_node_address(adr),
    .i_node_address_mask(msk), .i_buf_wr(wr), .i_buf_wdata(wdata), .i_tx_ninth_bit(tb8),
    .i_receive_flag_clr(rclr), .i_frame_error_clr(fclr), .i_break_clr(bclr),
    .o_rx_data(rx_data), .o_rx_ninth_bit(rx9), .o_receive_flag(rflag),
    .o_frame_error_flag(feflag), .o_break_flag(bflag), .o_tx_irq(tirq), .o_tx_busy(busy),
    .o_tx_buf_full(full), .o_break_reset(brst));
  umx_host #(.BIT_CYCLES(BC)) u_umx_host (.i_clk(clk), .i_nrst(nrst), .link(link.host),
    .i_nine(nine), .i_send(send), .i_send_data(sdata), .i_send_ninth(sninth),
    .i_send_break(brk), .o_send_ready(h_rdy), .o_rx_valid(h_val), .o_rx_data(h_data),
    .o_rx_ninth(h_9), .o_rx_frame_error(h_fe));
  umx_link_monitor u_mon (.i_clk(clk), .i_nrst(nrst), .to_dev(link.to_dev),
    .to_host(link.to_host), .i_buf_wr(wr), .i_dbl_buf_enable(dbl), .i_tx_irq_late(late),
    .i_multiproc_enable(mp), .i_receive_flag_clr(rclr), .i_break_clr(bclr),
    .i_break_reset_enable(bre), .i_port_enable(pen), .o_rx_data(rx_data),
    .o_rx_ninth_bit(rx9), .o_receive_flag(rflag), .o_break_flag(bflag), .o_tx_irq(tirq),
    .o_tx_busy(busy), .o_tx_buf_full(full), .o_break_reset(brst));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // log pulses at the falling edge, where registered outputs have settled
  always @(negedge clk)
  begin
    cyc++;
    if (tirq === 1'h1) ti.push_back(cyc);
    if (h_val === 1'h1)
    begin
      hd.push_back({h_9, h_data});
      ht.push_back(cyc);
    end
    if (brst === 1'h1) seen_brst = 1'h1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n
  // one-cycle pulse on a clear, send or write input
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc_n(1);
    s = 1'h0;
  endtask : pulse
  task automatic hsend(input logic [7:0] d, input logic n9, input int wt);
    sdata = d;
    sninth = n9;
    pulse(send);
    cyc_n(wt);
  endtask : hsend
  // ninth bit goes up before the byte so the buffer captures both together
  task automatic cwrite(input logic [7:0] d, input logic n9);
    tb8 = n9;
    wdata = d;
    pulse(wr);
  endtask : cwrite

  task automatic s_rx;
    chk("h_ready", 1, h_rdy);
    hsend(8'ha5, 1'h0, 14 * BC);
    chk("rx_flag", 1, rflag);
    chk("rx_data", 8'ha5, rx_data);
    chk("rx_ninth", 0, rx9);
    hsend(8'h3c, 1'h1, 14 * BC);
    chk("rx_kept", 8'ha5, rx_data);
    pulse(rclr);
    // 8-bit frame: the stop bit lands in the ninth-bit flag
    {mode, nine} = 3'h2; // mp stays off in mode 1
    hsend(8'h96, 1'h0, 12 * BC);
    chk("rx8_data", 8'h96, rx_data);
    chk("rx8_stop", 1, rx9);
    pulse(rclr);
    {mode, nine} = 3'h7;
  endtask : s_rx
  task automatic s_addr;
    logic [16:0] tab[5] = '{17'h1c000, 17'h1c201, 17'h1c100, 17'h1ff01, 17'h1c001};
    mp = 1'h1;
    hsend(8'h5a, 1'h1, 14 * BC);
    chk("rst_addr", 1, rflag);
    pulse(rclr);
    adr = 8'hc0;
    msk = 8'hfd;
    foreach (tab[i])
    begin
      hsend(tab[i][15:8], tab[i][16] & |tab[i][15:8] & (i != 0), 14 * BC);
      chk("addr_flag", tab[i][0], rflag);
      if (tab[i][0]) chk("addr_data", tab[i][15:8], rx_data);
      pulse(rclr);
    end
    mp = 1'h0;
  endtask : s_addr
  // a stop bit forced low: error in mode 2, none in the mode 3 select case
  task automatic s_fe;
    for (int k = 0; k < 2; k++)
    begin
      mode = k ? 2'h3 : 2'h2;
      mp = 1'h1;
      fe_sel = k[0];
      // high data bits keep the low stretch far short of a break
      hsend(8'hff, 1'h0, 10 * BC);
      brk = 1'h1;
      cyc_n(BC + 2);
      brk = 1'h0;
      cyc_n(4 * BC);
      chk("fe_flag", !k, feflag);
      chk("fe_rflag", 0, rflag);
      pulse(fclr);
    end
    mp = 1'h0;
  endtask : s_fe
  task automatic s_break;
    brk = 1'h1;
    cyc_n(10 * BC);
    brk = 1'h0;
    cyc_n(14 * BC);
    chk("brk_short", 0, bflag);
    // reset request only with both enables; wait out the frame the low line starts
    for (int k = 0; k < 3; k++)
    begin
      {bre, pen} = 2'(k + 1);
      seen_brst = 1'h0;
      brk = 1'h1;
      cyc_n(12 * BC);
      brk = 1'h0;
      cyc_n(14 * BC);
      chk("brk_flag", 1, bflag);
      chk("brk_reset", k == 2, seen_brst);
      pulse(bclr);
      cyc_n(1);
      chk("brk_clear", 0, bflag);
      pulse(rclr);
      pulse(fclr);
    end
  endtask : s_break
  task automatic s_dbl;
    int i0 = ti.size(), h0 = hd.size();
    dbl = 1'h1; // double buffer works in any mode, mode 0 included
    cwrite(8'h11, 1'h1);
    cyc_n(BC);
    chk("load_irq", i0 + 1, ti.size());
    cwrite(8'h22, 1'h0);
    chk("buf_full", 1, full);
    cyc_n(30 * BC);
    chk("irq_count", i0 + 2, ti.size());
    chk("irq_begin", 10 * BC, ti[i0 + 1] - ti[i0]);
    chk("tx_b0", 9'h111, hd[h0]);
    chk("tx_b1", 9'h022, hd[h0 + 1]);
    chk("tx_gap", 11 * BC, ht[h0 + 1] - ht[h0]);
  endtask : s_dbl
  task automatic s_last;
    int i0;
    isel = 1'h1;
    for (int k = 0; k < 2; k++)
    begin
      late = k[0];
      i0 = ti.size();
      cwrite(8'h44, 1'h1);
      cyc_n(15 * BC);
      chk("last_irq", i0 + 2, ti.size());
      chk("last_time", 10 * BC + k * (BC - 1), ti[i0 + 1] - ti[i0]);
    end
    {isel, late, dbl} = 3'h0;
  endtask : s_last
  task automatic s_single;
    int i0 = ti.size(), h0 = hd.size();
    cwrite(8'h55, 1'h1);
    cyc_n(BC);
    cwrite(8'h66, 1'h1); // ninth bit left alone while shifting
    chk("one_full", 0, full);
    cyc_n(20 * BC);
    chk("one_rx", h0 + 1, hd.size());
    chk("one_data", 9'h155, hd[h0]);
    chk("one_fe", 0, h_fe);
    chk("one_irq", i0 + 1, ti.size());
  endtask : s_single

  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // watchdog: the tests need about 1400 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    {nrst, fe_sel, mp, dbl, isel, late, wr, tb8, rclr, fclr, bclr, send, sninth, brk} = 14'h0;
    {adr, msk, wdata, sdata} = 32'h0;
    {bre, pen} = 2'h3;
    mode = 2'h3;
    nine = 1'h1;
    repeat (20) @(negedge clk);
    nrst = 1'h1;
    cyc_n(2);
    s_rx();
    s_addr();
    s_fe();
    s_break();
    s_dbl();
    s_last();
    s_single();
    give_verdict();
  end
endmodule : tb
